// [verilog/tca_cfg.svh]
`ifndef TCA_CFG_SVH
`define TCA_CFG_SVH
`define TCA_A_CTRL     6'h00
`define TCA_A_FINE     6'h01
`define TCA_A_DIR      6'h02
`define TCA_A_IRQ_ON   6'h03
`define TCA_A_FLAGS    6'h04
`define TCA_A_ACTION   6'h05
`define TCA_A_DETACH   6'h06
`define TCA_A_FORCE    6'h07
`define TCA_A_CH7MASK  6'h08
`define TCA_A_COUNTER  6'h09
`define TCA_A_TALLY    6'h0A
`define TCA_A_PORT     6'h0B
`define TCA_A_PIN      6'h0C
`define TCA_A_GPDIR    6'h0D
`define TCA_A_CAPEDGE  6'h0E
`define TCA_A_VALUE0   6'h10
`define TCA_F_CNTWRAP  8
`define TCA_F_TLYWRAP  9
`define TCA_F_TLYIN    10
`define TCA_RST_CTRL   11'h000
`define TCA_RST_8      8'h00
`define TCA_RST_16     16'h0000
`define TCA_RST_FLAGS  11'h000
`define TCA_D64_LAST   6'h3F
`define TCA_CNT_TOP    16'hFFFF
`endif

// [verilog/tca_pkg.sv]
package tca_pkg;
  typedef struct packed {
    logic [2:0] clock_divider_select;
    logic       wrap_toggle;
    logic       tally_polarity;
    logic       tally_gate_mode;
    logic       accumulator_on;
    logic       ch7_match_clears_counter;
    logic       fast_flag_clear;
    logic       fine_divider_enable;
    logic       main_counter_on;
  } tca_ctrl_t;
  typedef struct packed {
    logic [7:0] channel;
    logic       tally_input;
    logic       tally_wrap;
    logic       counter_wrap;
  } tca_irq_t;
  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_LOW    = 2'b10,
    ACT_HIGH   = 2'b11
  } tca_act_t;
endpackage : tca_pkg

// [verilog/tca_sync.sv]
`timescale 1ns/1ns
module tca_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule : tca_sync

// [verilog/tca_timer.sv]
// How it works
// RULE_01 - without fine divider, prescale by 1 to 128 from divider select
// RULE_02 - fine divider enable takes prescale from the eight-bit fine value
// RULE_03 - fine prescale factor is fine value plus one, 1 to 256
// RULE_04 - input channel copies main counter into its value on edge
// RULE_05 - pin pulses must last over two bus clocks to be seen
// RULE_06 - capture or match sets channel flag; enable raises request
// RULE_07 - flags clear by writing one, only while timer or tally on
// RULE_08 - output channel acts on pin at match unless pin detached
// RULE_09 - action and level pair zero means no pin action
// RULE_10 - pair 01 toggles, 10 drives low, 11 drives high
// RULE_11 - force bit does the compare action now without setting flag
// RULE_12 - channel 7 event overrides masked channels with channel 7 data
// RULE_13 - ch7 match clear runs counter 0 to nonzero ch7 value
// RULE_14 - ch7 match clears counter even while pin feeds the tally
// RULE_15 - port writes go to a latch seen when pin is plain output
// RULE_16 - preset strobe loads output register while detached and enabled
// RULE_17 - tally is a 16-bit counter with edge and gated modes
// RULE_18 - event mode counts channel 7 edges of chosen polarity
// RULE_19 - software clears ch7 action, level and mask to use input
// RULE_20 - tally wrap sets wrap flag; enable raises request
// RULE_21 - event counting works with the main timer off
// RULE_22 - gated mode counts divide-by-64 ticks during active level
// RULE_23 - trailing edge of gate sets input flag; enable raises request
// RULE_24 - divide-by-64 ticks come from prescaler, none when timer off (here divided from the bus clock, not the prescaler)
// RULE_25 - separate active-high request per channel, tally and wrap
// RULE_26 - fast clear: any tally register access clears tally flags
// RULE_27 - counter steps per prescaled tick, wrap sets counter flag
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "tca_cfg.svh"
module tca_timer (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [11:0]      paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [7:0]       pin_in,
  output logic      [7:0]       pin_out,
  output logic      [7:0]       pin_oe,
  output tca_pkg::tca_irq_t     irq
);
  tca_pkg::tca_ctrl_t ctrl_r;
  logic [7:0]  fine_r;
  logic [7:0]  dir_r;
  logic [10:0] irq_on_r;
  logic [10:0] flags_r;
  logic [7:0]  om_r;
  logic [7:0]  ol_r;
  logic [7:0]  detach_r;
  logic [7:0]  mask7_r;
  logic [7:0]  data7_r;
  logic [15:0] counter_r;
  logic [15:0] tally_r;
  logic [7:0]  port_r;
  logic [7:0]  gpdir_r;
  logic [15:0] capedge_r;
  logic [15:0] value_r [8];
  logic [7:0]  oc_r;
  logic [7:0]  oc_nxt;
  logic [7:0]  pre_r;
  logic [5:0]  d64_r;
  logic [7:0]  pin_s;
  logic [7:0]  pin_prev_r;
  logic        active_prev_r;
  logic [5:0]  widx;
  logic        acc_wr;
  logic        acc_any;
  logic        setup;
  logic        on;
  logic [7:0]  pre_top;
  logic        tick;
  logic        d64;
  logic        cnt_clr;
  logic        cnt_wrap;
  logic [7:0]  match;
  logic [7:0]  capture;
  logic        ch7_evt;
  logic [7:0]  force_w;
  logic [7:0]  preset_w;
  logic        tally_active;
  logic        tally_edge;
  logic        tally_inc;
  logic        tally_trail;
  logic [10:0] flag_set;
  logic [10:0] flag_clr;

  function automatic logic do_act(input logic cur,
                                  input logic om,
                                  input logic ol);
    logic r;
    r = cur;
    case (tca_pkg::tca_act_t'({om, ol}))
      tca_pkg::ACT_TOGGLE: r = ~cur;
      tca_pkg::ACT_LOW:    r = 1'b0;
      tca_pkg::ACT_HIGH:   r = 1'b1;
      default:             r = cur;
    endcase
    return r;
  endfunction : do_act
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       prev,
                                    input logic       cur);
    return (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
  endfunction : edge_hit
  // pins pass two flops before any use
  tca_sync #(
    .W (8)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pin_in),
    .q       (pin_s)
  );
  // bus decode, zero wait states
  assign widx    = paddr[7:2];
  assign setup   = psel & ~penable;
  assign acc_wr  = psel & penable & pwrite;
  assign acc_any = psel & penable;
  assign pready  = 1'b1;
  assign on      = ctrl_r.main_counter_on;
  // prescaler
  always_comb begin
    if (ctrl_r.fine_divider_enable) begin
      pre_top = fine_r; // see RULE_02 see RULE_03
    end else begin
      pre_top = 8'((9'h001 << ctrl_r.clock_divider_select) - 9'h001); // see RULE_01
    end
  end
  assign tick = on & (pre_r >= pre_top);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= `TCA_RST_8;
    end else if (!on || tick) begin
      pre_r <= `TCA_RST_8;
    end else begin
      pre_r <= pre_r + 8'h01;
    end
  end
  // divide-by-64 tick exists only while timer runs
  assign d64 = on & (d64_r == `TCA_D64_LAST); // see RULE_24
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d64_r <= 6'h00;
    end else if (!on) begin
      d64_r <= 6'h00;
    end else begin
      d64_r <= d64_r + 6'h01;
    end
  end
  // main counter
  assign cnt_clr = ctrl_r.ch7_match_clears_counter & (value_r[7] != 16'h0000)
                   & (counter_r == value_r[7]); // see RULE_13 see RULE_14
  assign cnt_wrap = tick & ~cnt_clr & (counter_r == `TCA_CNT_TOP); // see RULE_27
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_r <= `TCA_RST_16;
    end else if (acc_wr && widx == `TCA_A_COUNTER) begin
      counter_r <= pwdata[15:0];
    end else if (tick) begin
      counter_r <= cnt_clr ? 16'h0000 : counter_r + 16'h0001; // see RULE_27
    end
  end
  // compare and capture events
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      match[i]   = tick & dir_r[i] & (counter_r == value_r[i]);
      capture[i] = ~dir_r[i] &
                   edge_hit(capedge_r[2*i +: 2], pin_prev_r[i], pin_s[i]); // see RULE_04
    end
  end
  assign ch7_evt = match[7] | (cnt_wrap & ctrl_r.wrap_toggle);
  assign force_w  = (acc_wr && widx == `TCA_A_FORCE) ? pwdata[7:0]  : 8'h00;
  assign preset_w = (acc_wr && widx == `TCA_A_FORCE) ? pwdata[15:8] : 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_r <= `TCA_RST_8;
    end else begin
      pin_prev_r <= pin_s;
    end
  end
  // channel value registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        value_r[i] <= `TCA_RST_16;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (capture[i]) begin
          value_r[i] <= counter_r; // see RULE_04
        end else if (acc_wr && widx == `TCA_A_VALUE0 + 6'(i)) begin
          value_r[i] <= pwdata[15:0];
        end
      end
    end
  end
  // output compare registers
  always_comb begin
    for (int j = 0; j < 8; j++) begin
      oc_nxt[j] = oc_r[j];
      if (dir_r[j] && !detach_r[j] && (match[j] || force_w[j])) begin
        oc_nxt[j] = do_act(oc_r[j], om_r[j], ol_r[j]); // see RULE_08 see RULE_09 see RULE_10 see RULE_11
      end
      if (dir_r[j] && !detach_r[j] && ch7_evt && mask7_r[j]) begin
        oc_nxt[j] = data7_r[j]; // see RULE_12
      end
      if (preset_w[j] && dir_r[j] && detach_r[j] && on) begin
        oc_nxt[j] = do_act(oc_r[j], om_r[j], ol_r[j]); // see RULE_16
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_r <= `TCA_RST_8;
    end else begin
      oc_r <= oc_nxt;
    end
  end
  // pin drive: timer owns attached output channels, else port latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= `TCA_RST_8;
      pin_oe  <= `TCA_RST_8;
    end else begin
      for (int j = 0; j < 8; j++) begin
        pin_out[j] <= (dir_r[j] & ~detach_r[j]) ? oc_nxt[j] : port_r[j]; // see RULE_15 see RULE_16
        pin_oe[j]  <= (dir_r[j] & ~detach_r[j]) | gpdir_r[j];
      end
    end
  end
  // pulse accumulator on channel 7 pin
  assign tally_active = pin_s[7] ^ ctrl_r.tally_polarity; // see RULE_22
  assign tally_edge = ctrl_r.tally_polarity ? (~pin_prev_r[7] & pin_s[7])
                                            : (pin_prev_r[7] & ~pin_s[7]);
  assign tally_trail = ctrl_r.accumulator_on & ctrl_r.tally_gate_mode &
                       active_prev_r & ~tally_active; // see RULE_23
  always_comb begin
    if (!ctrl_r.accumulator_on) begin
      tally_inc = 1'b0;
    end else if (ctrl_r.tally_gate_mode) begin
      tally_inc = d64 & tally_active; // see RULE_22 see RULE_24
    end else begin
      tally_inc = tally_edge; // see RULE_18 see RULE_21
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_prev_r <= 1'b0;
    end else begin
      active_prev_r <= tally_active;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tally_r <= `TCA_RST_16;
    end else if (acc_wr && widx == `TCA_A_TALLY) begin
      tally_r <= pwdata[15:0];
    end else if (tally_inc) begin
      tally_r <= tally_r + 16'h0001; // see RULE_17
    end
  end
  // flags: set wins over clear
  always_comb begin
    flag_set = {
      tally_trail | (ctrl_r.accumulator_on & ~ctrl_r.tally_gate_mode
                     & tally_edge),
      tally_inc & (tally_r == `TCA_CNT_TOP), // see RULE_20
      cnt_wrap,
      match | capture // see RULE_06
    };
    flag_clr = 11'h000;
    if (acc_wr && widx == `TCA_A_FLAGS &&
        (on || ctrl_r.accumulator_on)) begin
      flag_clr = pwdata[10:0]; // see RULE_07
    end
    if (acc_any && widx == `TCA_A_TALLY && ctrl_r.fast_flag_clear) begin
      flag_clr[`TCA_F_TLYWRAP] = 1'b1; // see RULE_26
      flag_clr[`TCA_F_TLYIN]   = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= `TCA_RST_FLAGS;
    end else begin
      flags_r <= flag_set | (flags_r & ~flag_clr);
    end
  end
  // interrupt requests
  assign irq = {flags_r[7:0] & irq_on_r[7:0], // see RULE_06 see RULE_25
                flags_r[`TCA_F_TLYIN] & irq_on_r[`TCA_F_TLYIN],
                flags_r[`TCA_F_TLYWRAP] & irq_on_r[`TCA_F_TLYWRAP],
                flags_r[`TCA_F_CNTWRAP] & irq_on_r[`TCA_F_CNTWRAP]};
  // software control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= `TCA_RST_CTRL;
      fine_r    <= `TCA_RST_8;
      dir_r     <= `TCA_RST_8;
      irq_on_r  <= `TCA_RST_FLAGS;
      om_r      <= `TCA_RST_8;
      ol_r      <= `TCA_RST_8;
      detach_r  <= `TCA_RST_8;
      mask7_r   <= `TCA_RST_8;
      data7_r   <= `TCA_RST_8;
      port_r    <= `TCA_RST_8;
      gpdir_r   <= `TCA_RST_8;
      capedge_r <= `TCA_RST_16;
    end else if (acc_wr) begin
      case (widx)
        `TCA_A_CTRL:    ctrl_r    <= pwdata[10:0];
        `TCA_A_FINE:    fine_r    <= pwdata[7:0];
        `TCA_A_DIR:     dir_r     <= pwdata[7:0];
        `TCA_A_IRQ_ON:  irq_on_r  <= pwdata[10:0];
        `TCA_A_ACTION: begin
          om_r <= pwdata[7:0];
          ol_r <= pwdata[15:8];
        end
        `TCA_A_DETACH:  detach_r  <= pwdata[7:0];
        `TCA_A_CH7MASK: begin
          mask7_r <= pwdata[7:0];
          data7_r <= pwdata[15:8];
        end
        `TCA_A_PORT:    port_r    <= pwdata[7:0]; // see RULE_15
        `TCA_A_GPDIR:   gpdir_r   <= pwdata[7:0];
        `TCA_A_CAPEDGE: capedge_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end
  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      case (widx)
        `TCA_A_CTRL:    prdata <= {21'h0, ctrl_r};
        `TCA_A_FINE:    prdata <= {24'h0, fine_r};
        `TCA_A_DIR:     prdata <= {24'h0, dir_r};
        `TCA_A_IRQ_ON:  prdata <= {21'h0, irq_on_r};
        `TCA_A_FLAGS:   prdata <= {21'h0, flags_r};
        `TCA_A_ACTION:  prdata <= {16'h0, ol_r, om_r};
        `TCA_A_DETACH:  prdata <= {24'h0, detach_r};
        `TCA_A_FORCE:   prdata <= 32'h0000_0000;
        `TCA_A_CH7MASK: prdata <= {16'h0, data7_r, mask7_r};
        `TCA_A_COUNTER: prdata <= {16'h0, counter_r};
        `TCA_A_TALLY:   prdata <= {16'h0, tally_r};
        `TCA_A_PORT:    prdata <= {24'h0, port_r};
        `TCA_A_PIN:     prdata <= {24'h0, pin_s};
        `TCA_A_GPDIR:   prdata <= {24'h0, gpdir_r};
        `TCA_A_CAPEDGE: prdata <= {16'h0, capedge_r};
        default: begin
          if (widx[5:3] == 3'h2) begin
            prdata <= {16'h0, value_r[widx[2:0]]};
          end else begin
            pslverr <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule : tca_timer

// [verif/tca_monitor.sv]
`timescale 1ns/1ns
module tca_monitor (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic [11:0]  paddr,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [31:0]  pwdata,
  input wire logic [7:0]   pin_in,
  input wire logic [7:0]   pin_out,
  input wire logic [7:0]   pin_oe,
  input tca_pkg::tca_irq_t irq
);
  logic        wr;
  logic [5:0]  idx;
  logic [10:0] ctl_r;
  logic [10:0] en_r;
  logic [7:0]  dir_r;
  logic [7:0]  det_r;
  logic [7:0]  gp_r;
  logic        rise1_r;
  assign wr  = psel & penable & pwrite;
  assign idx = paddr[7:2];
  // shadow of control bits written over the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r   <= 11'h000;
      en_r    <= 11'h000;
      dir_r   <= 8'h00;
      det_r   <= 8'h00;
      gp_r    <= 8'h00;
      rise1_r <= 1'b0;
    end else if (wr) begin
      if (idx == 6'h00) ctl_r <= pwdata[10:0];
      if (idx == 6'h03) en_r <= pwdata[10:0];
      if (idx == 6'h02) dir_r <= pwdata[7:0];
      if (idx == 6'h06) det_r <= pwdata[7:0];
      if (idx == 6'h0D) gp_r <= pwdata[7:0];
      if (idx == 6'h0E) rise1_r <= pwdata[2];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_chan_req_mask: assert property (
    (irq.channel & ~en_r[7:0]) == 8'h00) else $error("channel request");
  a_tally_wrap_mask: assert property (
    irq.tally_wrap |-> en_r[9]) else $error("tally wrap request");
  a_gate_req_mask: assert property (
    irq.tally_input |-> en_r[10]) else $error("tally input request");
  a_cnt_req_mask: assert property (
    irq.counter_wrap |-> en_r[8]) else $error("counter wrap request");
  a_reset_quiet: assert property (
    $rose(presetn) |-> irq == 11'h000 && pin_oe == 8'h00)
    else $error("outputs active after reset");
  a_clear_needs_on: assert property (
    wr && idx == 6'h04 && !ctl_r[0] && !ctl_r[4]
    |=> ($past(irq) & ~irq) == 11'h000) else $error("flag cleared while off");
  a_force_no_flag: assert property (
    wr && idx == 6'h07 && !ctl_r[0] |=> (irq.channel
    & ~$past(irq.channel) & $past(pwdata[7:0] & dir_r)) == 8'h00)
    else $error("force set a flag");
  a_pin_drive_ok: assert property (
    pin_oe == ((dir_r & ~det_r) | gp_r)
    || pin_oe == $past((dir_r & ~det_r) | gp_r)) else $error("pin enable");
  a_capture_flag: assert property (
    $rose(pin_in[1]) && !dir_r[1] && rise1_r && en_r[1]
    |-> ##[1:4] irq.channel[1]) else $error("capture flag late");
  a_fast_clear: assert property (
    psel && penable && idx == 6'h0A && ctl_r[2] && ctl_r[4]
    |=> !irq.tally_wrap && !irq.tally_input) else $error("fast clear");
  c_cnt_wrap: cover property (irq.counter_wrap);
  c_tally_wrap: cover property ($rose(irq.tally_wrap));
  c_pin_rise: cover property ($rose(pin_out[0]));
endmodule : tca_monitor
bind tca_timer tca_monitor mon_u (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .pin_in, .pin_out, .pin_oe, .irq);

// [verif/tca_pin_model.sv]
`timescale 1ns/1ns
module tca_pin_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext,
  output logic      [7:0] pin_in
);
  // pin level: device where it drives, far side elsewhere
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : tca_pin_model

// [verif/tb.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic              pready;
  logic              pslverr;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic [31:0]       q;
  logic [31:0]       q1;
  logic [7:0]        ext = 8'h00;
  logic [7:0]        pin_in;
  logic [7:0]        pin_out;
  logic [7:0]        pin_oe;
  logic [7:0]        fv;
  tca_pkg::tca_irq_t irq;
  int                e;
  int                err_count = 0;
  int                num_checks = 0;
  always #5 pclk = ~pclk;
  tca_pin_model pm_u (.pin_out, .pin_oe, .ext, .pin_in);
  tca_timer dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .irq);
  task automatic xfer(input logic w, input logic [5:0] i,
                      input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {4'h0, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
    @(negedge pclk);
  endtask : idle
  task automatic pulse(input int b, input int c);
    @(posedge pclk);
    ext[b] <= 1'b1;
    repeat (c) @(posedge pclk);
    ext[b] <= 1'b0;
    idle(4);
  endtask : pulse
  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    idle(1);
    `CHK(irq, 11'h000)
    xfer(1'b0, 6'h3C, 32'h0);
    `CHK(pslverr, 1'b1)
    for (int s = 0; s < 11; s++) begin
      fv = (s == 8) ? 8'h00 : (s == 9) ? 8'h04 : 8'hFF;
      xfer(1'b1, 6'h01, {24'h0, fv});
      xfer(1'b1, 6'h00, {21'h0, 3'(s), 6'h00, s > 7, 1'b1});
      e = (s > 7) ? 1024 / (fv + 1) : 1024 >> s;
      xfer(1'b0, 6'h09, 32'h0);
      q1 = q;
      idle(1021);
      xfer(1'b0, 6'h09, 32'h0);
      `CHK(q[15:0] - q1[15:0] + 16'd1 - e <= 2, 1'b1)
    end
    xfer(1'b1, 6'h03, 32'h703);
    xfer(1'b1, 6'h00, 32'h1);
    xfer(1'b1, 6'h09, 32'hFFFA);
    idle(10);
    `CHK(irq.counter_wrap, 1'b1)
    xfer(1'b1, 6'h00, 32'h0);
    xfer(1'b1, 6'h04, 32'h100);
    idle(1);
    `CHK(irq.counter_wrap, 1'b1)
    xfer(1'b1, 6'h00, 32'h1);
    xfer(1'b1, 6'h04, 32'h100);
    idle(1);
    `CHK(irq.counter_wrap, 1'b0)
    xfer(1'b1, 6'h02, 32'h1);
    xfer(1'b1, 6'h10, 32'h100);
    for (int c = 3; c >= 0; c--) begin
      xfer(1'b1, 6'h05, {23'h0, c[0], 7'h00, c[1]});
      xfer(1'b1, 6'h09, 32'hFA);
      idle(12);
      `CHK(pin_out[0], (c != 2) ? 1'b1 : 1'b0)
      `CHK(pin_oe[0], 1'b1)
    end
    `CHK(irq.channel[0], 1'b1)
    xfer(1'b1, 6'h05, 32'h1);
    xfer(1'b1, 6'h06, 32'h1);
    xfer(1'b1, 6'h07, 32'h100);
    xfer(1'b1, 6'h06, 32'h0);
    idle(2);
    `CHK(pin_out[0], 1'b0)
    xfer(1'b1, 6'h0B, 32'h1);
    idle(2);
    `CHK(pin_out[0], 1'b0)
    xfer(1'b1, 6'h06, 32'h1);
    idle(2);
    `CHK(pin_out[0], 1'b1)
    `CHK(pin_oe[0], 1'b0)
    xfer(1'b1, 6'h0D, 32'h1);
    idle(2);
    `CHK(pin_oe[0], 1'b1)
    xfer(1'b0, 6'h0C, 32'h0);
    `CHK(q[0], 1'b1)
    xfer(1'b1, 6'h0D, 32'h0);
    xfer(1'b1, 6'h06, 32'h0);
    xfer(1'b1, 6'h04, 32'h1);
    xfer(1'b1, 6'h00, 32'h0);
    xfer(1'b1, 6'h05, 32'h100);
    xfer(1'b1, 6'h07, 32'h1);
    idle(2);
    `CHK(pin_out[0], 1'b1)
    `CHK(irq.channel[0], 1'b0)
    xfer(1'b1, 6'h0E, 32'h4);
    xfer(1'b1, 6'h00, 32'h701);
    xfer(1'b1, 6'h09, 32'h1234);
    pulse(1, 5);
    xfer(1'b0, 6'h11, 32'h0);
    q1 = q;
    xfer(1'b0, 6'h09, 32'h0);
    `CHK(q[15:0] - q1[15:0] <= 1 && q1[15:0] - 16'h1234 <= 1, 1'b1)
    `CHK(irq.channel[1], 1'b1)
    xfer(1'b1, 6'h02, 32'h81);
    xfer(1'b1, 6'h17, 32'h5);
    xfer(1'b1, 6'h09, 32'h0);
    xfer(1'b1, 6'h00, 32'h19);
    idle(20);
    xfer(1'b0, 6'h09, 32'h0);
    `CHK(q[15:0] <= 16'h0005, 1'b1)
    xfer(1'b1, 6'h08, 32'h1);
    idle(8);
    `CHK(pin_out[0], 1'b0)
    xfer(1'b1, 6'h08, 32'h101);
    idle(8);
    `CHK(pin_out[0], 1'b1)
    xfer(1'b1, 6'h02, 32'h1);
    xfer(1'b1, 6'h08, 32'h1);
    xfer(1'b1, 6'h00, 32'h81);
    xfer(1'b1, 6'h09, 32'hFFFA);
    idle(10);
    `CHK(pin_out[0], 1'b0)
    xfer(1'b1, 6'h08, 32'h0);
    xfer(1'b1, 6'h00, 32'h50);
    xfer(1'b1, 6'h0A, 32'hFFFF);
    pulse(7, 4);
    pulse(7, 4);
    xfer(1'b0, 6'h0A, 32'h0);
    `CHK(q[15:0], 16'h0001)
    idle(1);
    `CHK(irq.tally_wrap, 1'b1)
    xfer(1'b1, 6'h00, 32'h54);
    xfer(1'b0, 6'h0A, 32'h0);
    idle(1);
    `CHK(irq.tally_wrap, 1'b0)
    xfer(1'b1, 6'h00, 32'h30);
    xfer(1'b1, 6'h0A, 32'h0);
    pulse(7, 200);
    xfer(1'b0, 6'h0A, 32'h0);
    `CHK(q[15:0], 16'h0000)
    xfer(1'b1, 6'h00, 32'h31);
    xfer(1'b1, 6'h04, 32'h700);
    xfer(1'b1, 6'h0A, 32'h0);
    pulse(7, 640);
    xfer(1'b0, 6'h0A, 32'h0);
    `CHK(q[15:0] + 16'd1 - 16'd10 <= 2, 1'b1)
    idle(1);
    `CHK(irq.tally_input, 1'b1)
    summarize();
  end
endmodule : tb
